// File: design/sacr_pkg.sv
// Shared constants for the converter readout link
package sacr_pkg;
    localparam int RESULT_W = 18;
    localparam logic [4:0] DATA_BITS = 5'd18;
    localparam logic [4:0] BUSY_BITS = 5'd19;
    localparam int CONV_MIN_NS = 1000;
    localparam int CONV_MAX_NS = 2500;
    localparam int CONV_DEF_NS = 1600;
    localparam int LINK_PERIOD_NS = 160;
    localparam int CONV_MIN_CYC = (CONV_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / LINK_PERIOD_NS;
    localparam int CONV_DEF_CYC = CONV_DEF_NS / LINK_PERIOD_NS;
    localparam int CORE_PERIOD_NS = 5;
    localparam int CONV_MAX_CORE = (CONV_MAX_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS + 8;
    // Serial clock half period spans five link clocks so the synchronised edge is seen
    localparam int SCLK_DIV = 5 * LINK_PERIOD_NS / CORE_PERIOD_NS;
    // Trigger pulses last four link clocks so three-flop sampling catches them
    localparam int TRIG_HOLD_CORE = 4 * LINK_PERIOD_NS / CORE_PERIOD_NS;
    localparam logic [RESULT_W-1:0] RESULT_ZERO = 18'h00000;
endpackage

// File: design/sacr_if.sv
// Link wires between converter and host
`timescale 1ns/1ps
`default_nettype none
interface sacr_if;
    logic conversion_trigger;
    logic serial_in;
    logic sclk;
    logic sdo;
    logic sdo_oe;
    wire logic sdo_line;
    assign sdo_line = sdo_oe ? sdo : 1'b1;
    modport device (input conversion_trigger, input serial_in, input sclk,
        output sdo, output sdo_oe);
    modport host (output conversion_trigger, output serial_in, output sclk,
        input sdo_line);
endinterface
`default_nettype wire

// File: design/sacr_device.sv
// Converter digital end: mode select, conversion timing and serial readout
`timescale 1ns/1ps
`default_nettype none
module sacr_device
    import sacr_pkg::*;
#(
    parameter int CONV_CYC = CONV_DEF_CYC
) (
    input wire logic link_clk,
    input wire logic resetn,
    sacr_if.device lnk,
    input wire logic [sacr_pkg::RESULT_W-1:0] sample_value,
    output logic mode_chip_select,
    output logic converting,
    output logic powered_down
);
    import sacr_pkg::*;

    typedef enum logic [1:0] {
        ST_ACQ = 2'b00,
        ST_CONV = 2'b01,
        ST_READ = 2'b10
    } sacr_state_e;

    // Everything the converter end remembers
    typedef struct packed {
        sacr_state_e st;
        logic [7:0] cnt;
        logic [4:0] falls;
        logic [RESULT_W-1:0] shreg;
        logic busy_mode;
        logic oe;
        logic dout;
        logic cs_mode;
        logic [2:0] trig_s;
        logic [2:0] sclk_s;
        logic [2:0] din_s;
        logic trig_lvl;
        logic sclk_lvl;
        logic conv;
        logic pdn;
    } sacr_dev_s;

    sacr_dev_s q, d;
    logic trig_agree;
    logic sclk_agree;
    logic trig_rise;
    logic trig_fall;
    logic sclk_fall;

    ////////////////////////////////////////////////////////////////////////
    // Link pins come from the host clock: three flops each, and a trigger
    // or clock level is accepted only once the second and third stages
    // agree, so a metastable first stage never reaches the state logic
    assign trig_agree = (q.trig_s[1] == q.trig_s[2]);
    assign sclk_agree = (q.sclk_s[1] == q.sclk_s[2]);

    // Edges against the last accepted level
    assign trig_rise = trig_agree & q.trig_s[2] & ~q.trig_lvl;
    assign trig_fall = trig_agree & ~q.trig_s[2] & q.trig_lvl;
    assign sclk_fall = sclk_agree & ~q.sclk_s[2] & q.sclk_lvl;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d = q;
        // Synchroniser stages
        d.trig_s = {q.trig_s[1:0], lnk.conversion_trigger};
        d.sclk_s = {q.sclk_s[1:0], lnk.sclk};
        d.din_s = {q.din_s[1:0], lnk.serial_in};
        // Accepted levels follow agreeing stages only
        if (trig_agree) begin
            d.trig_lvl = q.trig_s[2];
        end
        if (sclk_agree) begin
            d.sclk_lvl = q.sclk_s[2];
        end
        if (trig_rise) begin
            // Output off, mode latched, conversion starts
            d.st = ST_CONV;
            d.oe = 1'b0;
            d.cs_mode = q.din_s[2];
            d.cnt = 8'h00;
            d.falls = 5'h00;
        end else begin
            case (q.st)
                ST_ACQ: begin
                    // Idle: output stays as the last readout left it
                    d.oe = q.oe;
                end
                ST_CONV: begin
                    // Runs to its count unless a new trigger rise restarts it
                    d.cnt = q.cnt + 8'h01;
                    if (q.cnt == 8'(CONV_CYC - 1)) begin
                        d.st = ST_READ;
                        d.shreg = sample_value;
                        d.falls = 5'h00;
                        // Trigger level at the end picks the readout form
                        d.busy_mode = ~q.trig_lvl;
                        if (!q.trig_lvl) begin
                            d.oe = 1'b1;
                            d.dout = 1'b0;
                        end
                    end
                end
                ST_READ: begin
                    // Serial clock acts only here, after conversion
                    if (!q.busy_mode && trig_fall) begin
                        d.oe = 1'b1;
                        d.dout = q.shreg[RESULT_W-1];
                        d.shreg = {q.shreg[RESULT_W-2:0], 1'b0};
                    end else if (sclk_fall && q.oe) begin
                        // Bit changes only on falls, stands over rise
                        d.falls = q.falls + 5'h01;
                        d.dout = q.shreg[RESULT_W-1];
                        d.shreg = {q.shreg[RESULT_W-2:0], 1'b0};
                        if (q.falls + 5'h01 == (q.busy_mode ? BUSY_BITS : DATA_BITS)) begin
                            d.oe = 1'b0;
                            d.st = ST_ACQ;
                        end
                    end
                end
                default: d.st = ST_ACQ;
            endcase
        end
        // Status flags registered so outputs come from flops
        d.conv = (d.st == ST_CONV);
        d.pdn = (d.st != ST_CONV);
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers; synchronisers reset to the idle pin levels so no false
    // edge follows reset
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '{
                st: ST_ACQ,
                cnt: 8'h00,
                falls: 5'h00,
                shreg: RESULT_ZERO,
                busy_mode: 1'b0,
                oe: 1'b0,
                dout: 1'b0,
                cs_mode: 1'b1,
                trig_s: 3'h7,
                sclk_s: 3'h0,
                din_s: 3'h7,
                trig_lvl: 1'b1,
                sclk_lvl: 1'b0,
                conv: 1'b0,
                pdn: 1'b1
            };
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from state
    assign lnk.sdo = q.dout;
    assign lnk.sdo_oe = q.oe;
    assign mode_chip_select = q.cs_mode;
    assign converting = q.conv;
    assign powered_down = q.pdn;
endmodule
`default_nettype wire

// File: design/sacr_host.sv
// Host end: starts conversions and reads results over three wires
`timescale 1ns/1ps
`default_nettype none
module sacr_host
    import sacr_pkg::*;
#(
    parameter int WAIT_CYC = CONV_MAX_CORE
) (
    input wire logic core_clk,
    input wire logic resetn,
    sacr_if.host lnk,
    input wire logic start,
    input wire logic use_busy,
    output logic [sacr_pkg::RESULT_W-1:0] result,
    output logic result_valid,
    output logic ready
);
    import sacr_pkg::*;

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_CONV = 3'b001,
        HS_SEL = 3'b010,
        HS_SHIFT = 3'b011,
        HS_DONE = 3'b100,
        HS_PRE = 3'b101
    } sacr_hst_e;

    typedef struct packed {
        sacr_hst_e st;
        logic [15:0] cnt;
        logic [4:0] bits;
        logic [7:0] div;
        logic busy;
        logic trig;
        logic sclk;
        logic [RESULT_W-1:0] sh;
        logic [RESULT_W-1:0] res;
        logic vld;
        logic [2:0] sync;
        logic rdy;
    } sacr_hst_s;

    sacr_hst_s q, d;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: trigger rise, wait max time, select, clock out bits
    always_comb begin
        d = q;
        d.vld = 1'b0;
        d.sync = {q.sync[1:0], lnk.sdo_line};
        case (q.st)
            HS_IDLE: begin
                if (start) begin
                    // Trigger idles high: drop it first to make a rise
                    d.trig = 1'b0;
                    d.busy = use_busy;
                    d.cnt = 16'h0000;
                    d.st = HS_PRE;
                end
            end
            HS_PRE: begin
                d.cnt = q.cnt + 16'h0001;
                if (q.cnt == 16'(TRIG_HOLD_CORE)) begin
                    d.trig = 1'b1;
                    d.cnt = 16'h0000;
                    d.st = HS_CONV;
                end
            end
            HS_CONV: begin
                // Without busy the trigger stays high to the wait end
                d.cnt = q.cnt + 16'h0001;
                if (q.busy && q.cnt == 16'(TRIG_HOLD_CORE)) begin
                    d.trig = 1'b0;
                end
                if (q.cnt == 16'(WAIT_CYC)) begin
                    d.trig = 1'b0;
                    d.cnt = 16'h0000;
                    d.bits = 5'h00;
                    d.div = 8'h00;
                    d.st = HS_SEL;
                end
            end
            HS_SEL: begin
                d.cnt = q.cnt + 16'h0001;
                if (q.cnt == 16'(SCLK_DIV * 2)) begin
                    d.st = HS_SHIFT;
                end
            end
            HS_SHIFT: begin
                // Capture just before each fall, while the bit stands
                d.div = q.div + 8'h01;
                if (q.div == 8'(SCLK_DIV - 1)) begin
                    d.div = 8'h00;
                    d.sclk = ~q.sclk;
                    if (q.sclk) begin
                        d.sh = {q.sh[RESULT_W-2:0], q.sync[2]};
                        d.bits = q.bits + 5'h01;
                        if (q.bits + 5'h01 == (q.busy ? BUSY_BITS : DATA_BITS)) begin
                            d.st = HS_DONE;
                        end
                    end
                end
            end
            HS_DONE: begin
                d.trig = 1'b1;
                d.sclk = 1'b0;
                d.res = q.sh;
                d.vld = 1'b1;
                d.st = HS_IDLE;
            end
            default: d.st = HS_IDLE;
        endcase
        d.rdy = (d.st == HS_IDLE);
    end

    // Registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '{st: HS_IDLE, cnt: 16'h0000, bits: 5'h00, div: 8'h00, busy: 1'b0,
                trig: 1'b1, sclk: 1'b0, sh: RESULT_ZERO, res: RESULT_ZERO,
                vld: 1'b0, sync: 3'h7, rdy: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign lnk.conversion_trigger = q.trig;
    assign lnk.serial_in = 1'b1;
    assign lnk.sclk = q.sclk;
    assign result = q.res;
    assign result_valid = q.vld;
    assign ready = q.rdy;
endmodule
`default_nettype wire

// File: testbench/sacr_link_chk.sv
// Link-side assertions for the converter readout
`timescale 1ns/1ps
`default_nettype none
module sacr_link_chk #(
    parameter int CONV_CYC = 10
) (
    input wire logic link_clk,
    input wire logic resetn,
    input wire logic conversion_trigger,
    input wire logic serial_in,
    input wire logic sclk,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic mode_chip_select,
    input wire logic converting,
    input wire logic powered_down
);
    logic [4:0] conv_q;
    logic [4:0] fall_q;
    logic sclk_q;
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    // Conversion length and clock falls while driving
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            conv_q <= 5'h00;
            fall_q <= 5'h00;
            sclk_q <= 1'b0;
        end else begin
            conv_q <= converting ? conv_q + 5'h01 : 5'h00;
            fall_q <= !sdo_oe ? 5'h00 : fall_q + 5'(sclk_q && !sclk);
            sclk_q <= sclk;
        end
    end
    ////////////////////////////////////////
    // Link behaviour
    trig_rise_off_a: assert property ($rose(conversion_trigger) |-> ##[1:5] !sdo_oe)
        else $error("output still driven after trigger rise");
    conv_start_a: assert property ($rose(conversion_trigger) |-> ##[1:5] converting)
        else $error("trigger rise did not start a conversion");
    conv_len_a: assert property ($fell(converting) |-> conv_q == 5'(CONV_CYC))
        else $error("conversion length wrong");
    conv_done_a: assert property ($fell(converting) |-> powered_down)
        else $error("not powered down after conversion");
    busy_bit_a: assert property ($fell(converting) && !conversion_trigger |-> sdo_oe && !sdo)
        else $error("busy bit missing");
    no_busy_a: assert property ($fell(converting) && conversion_trigger |-> !sdo_oe)
        else $error("busy bit driven with trigger high");
    mode_sel_a: assert property ($rose(converting) |-> mode_chip_select == $past(serial_in))
        else $error("mode flag differs from serial input");
    quiet_conv_a: assert property (converting |-> !sdo_oe)
        else $error("output driven during conversion");
    bit_stand_a: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !sclk)
        else $error("output bit changed while clock high");
    fall_cap_a: assert property (sdo_oe |-> fall_q <= 5'd19)
        else $error("output driven past last clock fall");
    busy_c: cover property ($fell(converting) && !conversion_trigger);
    plain_c: cover property ($fell(converting) && conversion_trigger);
    release_c: cover property ($fell(sdo_oe));
endmodule
`default_nettype wire

// File: testbench/sar_adc_chip_select_readout_bench.sv
// Bench joining host and converter ends over the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t mismatch %h expected %h", $time, g, e); end end
module sar_adc_chip_select_readout_bench;
    import sacr_pkg::*;
    typedef struct packed {logic busy; logic [RESULT_W-1:0] val;} sacr_row_s;
    logic core_clk, link_clk, resetn, start, use_busy, result_valid, ready;
    logic mode_chip_select, converting, powered_down;
    logic [RESULT_W-1:0] sample_value, result;
    logic [18:0] cap;
    int error_cnt, samples_checked, rises;
    sacr_row_s rows [8];
    sacr_if lnk_if ();
    sacr_device #(.CONV_CYC(CONV_DEF_CYC)) i_sacr_device (.link_clk(link_clk),
        .resetn(resetn), .lnk(lnk_if.device), .sample_value(sample_value),
        .mode_chip_select(mode_chip_select), .converting(converting),
        .powered_down(powered_down));
    sacr_host i_sacr_host (.core_clk(core_clk), .resetn(resetn), .lnk(lnk_if.host),
        .start(start), .use_busy(use_busy), .result(result),
        .result_valid(result_valid), .ready(ready));
    sacr_link_chk #(.CONV_CYC(CONV_DEF_CYC)) i_sacr_link_chk (.link_clk(link_clk),
        .resetn(resetn), .conversion_trigger(lnk_if.conversion_trigger),
        .serial_in(lnk_if.serial_in), .sclk(lnk_if.sclk), .sdo(lnk_if.sdo),
        .sdo_oe(lnk_if.sdo_oe), .mode_chip_select(mode_chip_select),
        .converting(converting), .powered_down(powered_down));
    ////////////////////////////////////////
    // Clocks, unrelated in phase
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        link_clk = 1'b0;
        #37.3;
        forever #80 link_clk = ~link_clk;
    end
    // Wire capture on serial clock rises
    always @(posedge lnk_if.sclk) begin
        cap <= {cap[17:0], lnk_if.sdo_line};
        rises <= rises + 1;
    end
    ////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Bounded wait on a host flag at the falling edge
    task automatic wait_flag(input bit want_valid);
        int n;
        n = 0;
        while ((want_valid ? result_valid : ready) !== 1'b1 && n < 10000) begin
            @(negedge core_clk);
            n++;
        end
        if ((want_valid ? result_valid : ready) !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t host flag timeout", $time);
            final_report();
        end
    endtask
    // One full conversion and readout
    task automatic do_conv(input logic b, input logic [RESULT_W-1:0] v);
        wait_flag(1'b0);
        @(posedge core_clk);
        sample_value <= v;
        use_busy <= b;
        start <= 1'b1;
        cap = 19'h00000;
        rises = 0;
        @(posedge core_clk);
        start <= 1'b0;
        wait_flag(1'b1);
        `CHK(result, v)
        `CHK(cap, {1'b0, v})
        `CHK(rises, 18 + int'(b))
        `CHK(mode_chip_select, 1'b1)
        $display("test done busy %0d value %h", b, v);
    endtask
    ////////////////////////////////////////
    initial begin
        start = 1'b0;
        use_busy = 1'b0;
        sample_value = RESULT_ZERO;
        resetn = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        rows = '{'{1'b0, 18'h1ffff}, '{1'b0, 18'h20000}, '{1'b0, 18'h3ffff},
            '{1'b0, 18'h00001}, '{1'b1, 18'h1ffff}, '{1'b1, 18'h20000},
            '{1'b1, 18'h2aaaa}, '{1'b1, 18'h15555}};
        repeat (10) @(posedge link_clk);
        @(posedge core_clk) resetn <= 1'b1;
        foreach (rows[i]) do_conv(rows[i].busy, rows[i].val);
        // Reset in mid-conversion, then a busy and a plain readout back to back
        @(posedge core_clk) start <= 1'b1;
        @(posedge core_clk) start <= 1'b0;
        repeat (200) @(posedge core_clk);
        resetn <= 1'b0;
        @(negedge core_clk);
        `CHK(lnk_if.sdo_line, 1'b1)
        `CHK(lnk_if.conversion_trigger, 1'b1)
        repeat (10) @(posedge link_clk);
        @(posedge core_clk) resetn <= 1'b1;
        do_conv(1'b1, 18'h20001);
        do_conv(1'b0, 18'h3fffe);
        $display("test done reset recovery");
        final_report();
    end
endmodule
`default_nettype wire
